/* File: pkg/sbe_pkg.sv */
package sbe_pkg;

    // ==========================================================
    // sizes
    // ==========================================================
    localparam int unsigned NUM_OUT  = 20;
    localparam int unsigned AXI_AW   = 8;
    localparam int unsigned AXI_DW   = 32;

    // ==========================================================
    // register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] OFS_SMB_EN   = 8'h00;
    localparam logic [7:0] OFS_MASK     = 8'h04;
    localparam logic [7:0] OFS_READBACK = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0c;
    localparam logic [7:0] OFS_OUT_EN   = 8'h10;

    localparam int unsigned ST_STRAP_BIT  = 0;
    localparam int unsigned ST_PGOOD_BIT  = 1;
    localparam int unsigned ST_REFRUN_BIT = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // reference clock counted lost after this long without an edge
    localparam int unsigned REF_LOSS_NS   = 100;
    localparam int unsigned REF_LOSS_CYC  =
        (REF_LOSS_NS * 1000) / CLK_PERIOD_PS;
    // strap read once the synchroniser has filled
    localparam logic [1:0]  STRAP_TAKE_CYC = 2'h2;

    // ==========================================================
    // types
    // ==========================================================
    typedef struct packed {
        logic load_n;
        logic clk;
        logic data;
    } sbe_pins_t;

    typedef enum logic [1:0] {
        SB_HOLD  = 2'b01,
        SB_SHIFT = 2'b10
    } sbe_state_t;

endpackage : sbe_pkg

/* File: core/sbe_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module sbe_sync #(
    parameter int unsigned W = 1
)(
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta   <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule : sbe_sync

`default_nettype wire

/* File: core/sbe_shift.sv */
`timescale 1ns/10ps
`default_nettype none

module sbe_shift #(
    parameter int unsigned N = 20
)(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             enable_i,
    input  wire sbe_pkg::sbe_pins_t pins_i,
    output var  logic [N-1:0]     shift_o,
    output var  logic             load_o,
    output var  logic             sdo_o
);

    sbe_pkg::sbe_state_t state;
    sbe_pkg::sbe_state_t next_state;
    logic                clk_d;
    logic                clk_rise;
    logic                do_shift;
    logic                do_load;

    assign clk_rise = pins_i.clk & ~clk_d;
    // clock edges only count while the strobe is high
    assign do_shift = (state == sbe_pkg::SB_SHIFT) & pins_i.load_n
                    & clk_rise;
    assign do_load  = (state == sbe_pkg::SB_SHIFT) & ~pins_i.load_n;

    always_comb
    begin
        case (state)
            sbe_pkg::SB_HOLD:
                next_state = (enable_i & pins_i.load_n) ?
                             sbe_pkg::SB_SHIFT : sbe_pkg::SB_HOLD;
            sbe_pkg::SB_SHIFT:
                next_state = do_load ? sbe_pkg::SB_HOLD : sbe_pkg::SB_SHIFT;
            default:
                next_state = sbe_pkg::SB_HOLD;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state   <= sbe_pkg::SB_HOLD;
            clk_d   <= 1'b0;
            shift_o <= '1;
            load_o  <= 1'b0;
            sdo_o   <= 1'b1;
        end
        else
        begin
            state  <= next_state;
            clk_d  <= pins_i.clk;
            load_o <= do_load;
            if (do_shift)
            begin
                // first bit in ends at the top stage
                shift_o <= {shift_o[N-2:0], pins_i.data};
                sdo_o   <= shift_o[N-2];
            end
        end
    end

    a_hold_when_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !pins_i.load_n |=> $stable(shift_o))
        else $error("shift register moved while strobe low");

    a_shift_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
        do_shift |=> shift_o == {$past(shift_o[N-2:0]), $past(pins_i.data)})
        else $error("shift step wrong");

    a_serial_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
        do_shift |=> sdo_o == shift_o[N-1])
        else $error("serial out not last stage");

endmodule : sbe_shift

`default_nettype wire

/* File: core/sbe_top.sv */
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - enables change glitch-free, only with reference running
// - strap low: sideband interface has no effect
// - mask bits reset to zero
// - set mask bit forces sideband enable
// - mask writable only after power good
// - readback copy refreshed on strobe fall
// - shift register never written by software
// - first bit shifted controls highest output
// - shift length equals output count
// - strobe high: sample data on clock rise
// - strobe fall copies shift to control
// - strobe low: clock and data ignored
// - serial out feeds next chained device
// - output on only when all enables agree
// - shift bits: one enables, reset ones
// - strap sampled once at power, static
// - sideband works before power good, no reference

module sbe_top #(
    parameter int unsigned        NUM_OUT     = sbe_pkg::NUM_OUT,
    parameter logic [NUM_OUT-1:0] OE_PIN_USED = '1
)(
    input  wire logic                      clk_i,
    input  wire logic                      rstn_i,
    // sideband pins
    input  wire logic                      sideband_enable_strap_i,
    input  wire logic                      sideband_clock_i,
    input  wire logic                      sideband_data_in_i,
    input  wire logic                      shift_load_n_i,
    output var  logic                      sideband_data_out_o,
    // device pins
    input  wire logic                      power_good_power_down_n_i,
    input  wire logic                      reference_clock_in_i,
    input  wire logic [NUM_OUT-1:0]        output_enable_pin_n_i,
    output var  logic [NUM_OUT-1:0]        output_enable_o,
    // axi4-lite slave
    input  wire logic [sbe_pkg::AXI_AW-1:0] s_axi_awaddr_i,
    input  wire logic                      s_axi_awvalid_i,
    output var  logic                      s_axi_awready_o,
    input  wire logic [sbe_pkg::AXI_DW-1:0] s_axi_wdata_i,
    input  wire logic [3:0]                s_axi_wstrb_i,
    input  wire logic                      s_axi_wvalid_i,
    output var  logic                      s_axi_wready_o,
    output var  logic [1:0]                s_axi_bresp_o,
    output var  logic                      s_axi_bvalid_o,
    input  wire logic                      s_axi_bready_i,
    input  wire logic [sbe_pkg::AXI_AW-1:0] s_axi_araddr_i,
    input  wire logic                      s_axi_arvalid_i,
    output var  logic                      s_axi_arready_o,
    output var  logic [sbe_pkg::AXI_DW-1:0] s_axi_rdata_o,
    output var  logic [1:0]                s_axi_rresp_o,
    output var  logic                      s_axi_rvalid_o,
    input  wire logic                      s_axi_rready_i
);

    localparam int unsigned SW = NUM_OUT + 6;
    localparam int unsigned PAD = sbe_pkg::AXI_DW - NUM_OUT;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [31:0] apply_strb(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    function automatic logic [31:0] widen(input logic [NUM_OUT-1:0] v);
        return {{PAD{1'b0}}, v};
    endfunction : widen

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [SW-1:0]      sync_q;
    sbe_pkg::sbe_pins_t pins_s;
    logic               strap_s;
    logic               pg_s;
    logic               ref_s;
    logic [NUM_OUT-1:0] oe_n_s;

    sbe_sync #(
        .W (SW)
    ) u_sync (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i ({output_enable_pin_n_i, reference_clock_in_i,
                   power_good_power_down_n_i, sideband_enable_strap_i,
                   shift_load_n_i, sideband_clock_i, sideband_data_in_i}),
        .sync_o  (sync_q)
    );

    assign pins_s  = sync_q[2:0];
    assign strap_s = sync_q[3];
    assign pg_s    = sync_q[4];
    assign ref_s   = sync_q[5];
    assign oe_n_s  = sync_q[SW-1:6];

    // ==========================================================
    // strap capture
    // ==========================================================
    logic [1:0] strap_cnt;
    logic       strap_on;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_cnt <= 2'h0;
            strap_on  <= 1'b0;
        end
        else if (strap_cnt == sbe_pkg::STRAP_TAKE_CYC)
        begin
            // taken once, held for good: a later change is ignored
            strap_cnt <= strap_cnt + 2'h1;
            strap_on  <= strap_s;
        end
        else if (strap_cnt < sbe_pkg::STRAP_TAKE_CYC)
        begin
            // parks past the take point so the counter never wraps
            strap_cnt <= strap_cnt + 2'h1;
        end
    end

    // ==========================================================
    // sideband shift register
    // ==========================================================
    logic [NUM_OUT-1:0] shift_q;
    logic               load_p;
    logic [NUM_OUT-1:0] ctrl;
    logic [NUM_OUT-1:0] readback;

    // runs from its own clock samples, independent of power good
    // and of the reference clock
    sbe_shift #(
        .N (NUM_OUT)
    ) u_shift (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .enable_i (strap_on),
        .pins_i   (pins_s),
        .shift_o  (shift_q),
        .load_o   (load_p),
        .sdo_o    (sideband_data_out_o)
    );

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl     <= '1;
            readback <= '1;
        end
        else if (load_p)
        begin
            ctrl     <= shift_q;
            readback <= shift_q;
        end
    end

    // ==========================================================
    // reference clock activity
    // ==========================================================
    logic        ref_d;
    logic [15:0] ref_cnt;
    logic        ref_run;
    logic        ref_edge;

    assign ref_edge = ref_s ^ ref_d;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ref_d   <= 1'b0;
            ref_cnt <= 16'h0;
            ref_run <= 1'b0;
        end
        else
        begin
            ref_d <= ref_s;
            if (ref_edge)
            begin
                ref_cnt <= 16'h0;
                ref_run <= 1'b1;
            end
            else if (ref_cnt == 16'(sbe_pkg::REF_LOSS_CYC))
            begin
                ref_run <= 1'b0;
            end
            else
            begin
                ref_cnt <= ref_cnt + 16'h1;
            end
        end
    end

    // ==========================================================
    // enable priority
    // ==========================================================
    logic [NUM_OUT-1:0] smb_en;
    logic [NUM_OUT-1:0] mask;
    logic [NUM_OUT-1:0] eff_sb;
    logic [NUM_OUT-1:0] pin_en;
    logic [NUM_OUT-1:0] next_en;

    assign eff_sb  = strap_on ? (ctrl | mask) : '1;
    // an output without an assigned pin ignores that term
    assign pin_en  = ~oe_n_s | ~OE_PIN_USED;
    assign next_en = smb_en & pin_en & eff_sb;

    // stands in for the per-output clock-gate sync: a decision only
    // lands while the reference is seen toggling
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            output_enable_o <= '0;
        end
        else if (ref_run)
        begin
            output_enable_o <= next_en;
        end
    end

    // ==========================================================
    // axi4-lite write
    // ==========================================================
    logic                      aw_got;
    logic                      w_got;
    logic [sbe_pkg::AXI_AW-1:0] aw_addr;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      aw_hs;
    logic                      w_hs;
    logic                      do_write;
    logic [sbe_pkg::AXI_AW-1:0] wa;
    logic [31:0]               wd;
    logic [3:0]                ws;
    logic                      wa_hit;
    logic                      wr_smb;
    logic                      wr_mask;
    logic                      next_aw_got;
    logic                      next_w_got;
    logic                      next_bvalid;
    logic [31:0]               smb_wr_val;
    logic [31:0]               mask_wr_val;

    assign aw_hs    = s_axi_awvalid_i & s_axi_awready_o;
    assign w_hs     = s_axi_wvalid_i & s_axi_wready_o;
    assign do_write = (aw_got | aw_hs) & (w_got | w_hs) & ~s_axi_bvalid_o;
    assign wa       = aw_got ? aw_addr : s_axi_awaddr_i;
    assign wd       = w_got ? w_data : s_axi_wdata_i;
    assign ws       = w_got ? w_strb : s_axi_wstrb_i;

    assign wa_hit   = (wa == sbe_pkg::OFS_SMB_EN) | (wa == sbe_pkg::OFS_MASK)
                    | (wa == sbe_pkg::OFS_READBACK)
                    | (wa == sbe_pkg::OFS_STATUS)
                    | (wa == sbe_pkg::OFS_OUT_EN);
    assign wr_smb   = do_write & (wa == sbe_pkg::OFS_SMB_EN);
    // mask writes before power good are dropped silently
    assign wr_mask  = do_write & (wa == sbe_pkg::OFS_MASK) & pg_s;

    assign smb_wr_val  = apply_strb(widen(smb_en), wd, ws);
    assign mask_wr_val = apply_strb(widen(mask), wd, ws);

    assign next_aw_got = (aw_got | aw_hs) & ~do_write;
    assign next_w_got  = (w_got | w_hs) & ~do_write;
    assign next_bvalid = do_write | (s_axi_bvalid_o & ~s_axi_bready_i);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            aw_addr         <= '0;
            w_data          <= 32'h0;
            w_strb          <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= sbe_pkg::RESP_OKAY;
        end
        else
        begin
            aw_got          <= next_aw_got;
            w_got           <= next_w_got;
            s_axi_awready_o <= ~next_aw_got & ~next_bvalid;
            s_axi_wready_o  <= ~next_w_got & ~next_bvalid;
            s_axi_bvalid_o  <= next_bvalid;
            if (aw_hs)
            begin
                aw_addr <= s_axi_awaddr_i;
            end
            if (w_hs)
            begin
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (do_write)
            begin
                s_axi_bresp_o <= wa_hit ? sbe_pkg::RESP_OKAY
                                        : sbe_pkg::RESP_SLVERR;
            end
        end
    end

    // readback and shift register have no write path
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            smb_en <= '1;
            mask   <= '0;
        end
        else
        begin
            if (wr_smb)
            begin
                smb_en <= smb_wr_val[NUM_OUT-1:0];
            end
            if (wr_mask)
            begin
                mask <= mask_wr_val[NUM_OUT-1:0];
            end
        end
    end

    // ==========================================================
    // axi4-lite read
    // ==========================================================
    logic        ar_hs;
    logic        next_rvalid;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic [31:0] status;

    assign status = {29'h0, ref_run, pg_s, strap_on};
    assign ar_hs  = s_axi_arvalid_i & s_axi_arready_o;
    assign next_rvalid = ar_hs | (s_axi_rvalid_o & ~s_axi_rready_i);

    always_comb
    begin
        rd_hit  = 1'b1;
        case (s_axi_araddr_i)
            sbe_pkg::OFS_SMB_EN:   rd_data = widen(smb_en);
            sbe_pkg::OFS_MASK:     rd_data = widen(mask);
            sbe_pkg::OFS_READBACK: rd_data = widen(readback);
            sbe_pkg::OFS_STATUS:   rd_data = status;
            sbe_pkg::OFS_OUT_EN:   rd_data = widen(output_enable_o);
            default:
            begin
                rd_data = 32'h0;
                rd_hit  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0;
            s_axi_rresp_o   <= sbe_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready_o <= ~next_rvalid;
            s_axi_rvalid_o  <= next_rvalid;
            if (ar_hs)
            begin
                s_axi_rdata_o <= rd_data;
                s_axi_rresp_o <= rd_hit ? sbe_pkg::RESP_OKAY
                                        : sbe_pkg::RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    a_strap_off_free: assert property (
        !strap_on |-> eff_sb == '1)
        else $error("sideband active with strap low");

    a_mask_forces_en: assert property (
        (eff_sb | ~mask) == '1)
        else $error("masked output not forced enabled");

    a_mask_no_pg: assert property (
        !pg_s |=> $stable(mask))
        else $error("mask changed before power good");

    a_readback_load: assert property (
        load_p |=> readback == $past(shift_q) && ctrl == readback)
        else $error("readback not refreshed on load");

    a_readback_hold: assert property (
        !load_p |=> $stable(readback) && $stable(ctrl))
        else $error("readback moved without load");

    a_out_follows: assert property (
        ref_run |=> output_enable_o == $past(next_en))
        else $error("output enable not the AND of sources");

    a_no_ref_hold: assert property (
        !ref_run |=> $stable(output_enable_o))
        else $error("output changed without reference");

    a_strap_static: assert property (
        strap_cnt == 2'h3 |=> $stable(strap_on))
        else $error("strap changed after capture");

endmodule : sbe_top

`default_nettype wire

/* File: sim/sbe_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none

// =====================================================
// sideband controller: strobe, clock and data driver
// =====================================================
module sbe_ctrl_model #(
    parameter int unsigned N = 20
)(
    input  wire logic clk_i,
    output var  logic sclk_o,
    output var  logic sdat_o,
    output var  logic load_n_o
);
    initial
    begin
        sclk_o   = 1'b0;
        sdat_o   = 1'b1;
        load_n_o = 1'b0;
    end

    // frame=0 toggles clock and data with the strobe held low
    task automatic send(input logic [N-1:0] pat, input int unsigned half,
                        input logic frame);
        int unsigned i;
        @(posedge clk_i);
        load_n_o <= frame;
        repeat (4) @(posedge clk_i);
        for (i = 0; i < N; i++)
        begin
            sdat_o <= pat[N-1-i];
            repeat (half) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (half) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        // data no longer held: show the inverse, not the last bit
        sdat_o <= ~pat[0];
        repeat (6) @(posedge clk_i);
        load_n_o <= 1'b0;
    endtask : send
endmodule : sbe_ctrl_model

`default_nettype wire

/* File: sim/sbe_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module sbe_top_tb;
    localparam int unsigned N = sbe_pkg::NUM_OUT;
    logic clk_i, rstn, strap, pg, rclk, rrun, sclk, sdat, ldn, sdo;
    logic [N-1:0] pins_n, oe, pat, mask, smb, old;
    logic [7:0]   awa, ara;
    logic [31:0]  wd, rdat, got;
    logic [1:0]   br, rr, resp;
    logic awv, awr, wv, wr_r, bv, brd, arv, arr, rv, rrd;
    logic [1:0]   rc;
    int n_errors, n_tests, k;

    sbe_top dut_u (.clk_i(clk_i), .rstn_i(rstn),
        .sideband_enable_strap_i(strap), .sideband_clock_i(sclk),
        .sideband_data_in_i(sdat), .shift_load_n_i(ldn),
        .sideband_data_out_o(sdo), .power_good_power_down_n_i(pg),
        .reference_clock_in_i(rclk), .output_enable_pin_n_i(pins_n),
        .output_enable_o(oe), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(br),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(brd), .s_axi_araddr_i(ara),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
        .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd));

    sbe_ctrl_model #(.N(N)) ctl_u (.clk_i(clk_i), .sclk_o(sclk),
        .sdat_o(sdat), .load_n_o(ldn));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // reference clock at an eighth of clk_i, stoppable
    always @(posedge clk_i)
    begin
        rc <= rc + 2'h1;
        if (rrun && rc == 2'h0)
            rclk <= ~rclk;
    end

    // =====================================================
    // bus and check tasks
    // =====================================================
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (e !== g)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_oe(input string nm, input logic [N-1:0] e, g);
        chk(nm, {12'h0, e}, {12'h0, g});
    endtask : chk_oe

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; brd <= 1'b1;
        fork
            begin do @(posedge clk_i); while (awr !== 1'b1); awv <= 1'b0; end
            begin do @(posedge clk_i); while (wr_r !== 1'b1); wv <= 1'b0; end
        join
        while (bv !== 1'b1) @(posedge clk_i);
        resp = br;
        brd <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        ara <= a; arv <= 1'b1; rrd <= 1'b1;
        do @(posedge clk_i); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge clk_i);
        got = rdat;
        resp = rr;
        rrd <= 1'b0;
    endtask : rd

    function automatic logic [N-1:0] exp_oe(input logic [N-1:0] s, p, b, m,
                                           input logic st);
        return s & ~p & (st ? (b | m) : '1);
    endfunction : exp_oe

    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    initial
    begin
        #100000;
        n_errors++;
        print_verdict();
    end

    // =====================================================
    // main sequence
    // =====================================================
    initial
    begin
        {rstn, pg, rclk, awv, wv, brd, arv, rrd, rc} = '0;
        {awa, ara, wd, pins_n} = '0;
        {strap, rrun} = 2'b11;
        void'($urandom(92694));
        repeat (8) @(posedge clk_i);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd(sbe_pkg::OFS_MASK);     chk("mask", 32'h0, got);
        rd(sbe_pkg::OFS_READBACK); chk("rb", 32'hfffff, got);
        chk("oe0", {12'h0, {N{1'b1}}}, {12'h0, oe});
        wr(sbe_pkg::OFS_MASK, 32'hfffff);
        rd(sbe_pkg::OFS_MASK);     chk("mask pg", 32'h0, got);
        wr(sbe_pkg::OFS_READBACK, 32'h0);
        rd(sbe_pkg::OFS_READBACK); chk("rb ro", 32'hfffff, got);
        wr(8'h40, 32'h0);          chk("resp", 32'h2, {30'h0, resp});
        rd(8'h40);                 chk("rresp", 32'h2, {30'h0, resp});
        chk("rd bad", 32'h0, got);
        pg <= 1'b1;
        repeat (6) @(posedge clk_i);
        for (k = 0; k < 4; k++)
        begin
            pat = N'($urandom); smb = ~N'($urandom & $urandom);
            mask = N'($urandom & $urandom); pins_n <= N'($urandom & $urandom);
            wr(sbe_pkg::OFS_MASK, {12'h0, mask});
            wr(sbe_pkg::OFS_SMB_EN, {12'h0, smb});
            rd(sbe_pkg::OFS_MASK); chk("mask", {12'h0, mask}, got);
            ctl_u.send(pat, 8, 1'b1);
            repeat (12) @(posedge clk_i);
            rd(sbe_pkg::OFS_READBACK); chk("rb", {12'h0, pat}, got);
            chk("sdo", {31'h0, pat[N-1]}, {31'h0, sdo});
            chk_oe("oe", exp_oe(smb, pins_n, pat, mask, 1'b1), oe);
        end
        ctl_u.send(~pat, 8, 1'b0);
        repeat (12) @(posedge clk_i);
        chk("sdo idle", {31'h0, pat[N-1]}, {31'h0, sdo});
        old = oe;
        rrun <= 1'b0;
        repeat (40) @(posedge clk_i);
        pat = N'($urandom);
        ctl_u.send(pat, 8, 1'b1);
        repeat (12) @(posedge clk_i);
        chk_oe("oe frozen", old, oe);
        rd(sbe_pkg::OFS_READBACK); chk("rb noref", {12'h0, pat}, got);
        rrun <= 1'b1;
        repeat (40) @(posedge clk_i);
        chk_oe("oe ref", exp_oe(smb, pins_n, pat, mask, 1'b1), oe);
        strap <= 1'b0; rstn <= 1'b0;
        repeat (8) @(posedge clk_i);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_i);
        ctl_u.send('0, 8, 1'b1);
        repeat (12) @(posedge clk_i);
        chk_oe("oe strap", exp_oe('1, pins_n, '0, '0, 1'b0), oe);
        print_verdict();
    end
endmodule : sbe_top_tb

`default_nettype wire
